//--- inc/hfcs_pkg.sv
package hfcs_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL_ONE  = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO  = 8'h04;
  localparam logic [7:0] OFS_PORT_FN   = 8'h08;
  localparam logic [7:0] OFS_WU_CMP    = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;
  // ==========================================================================
  // Field positions
  localparam int BIT_SRC_SEL  = 0;
  localparam int BIT_INT_EN   = 0;
  localparam int BIT_EXT_EN   = 1;
  localparam int BIT_SLOW_SEL = 2;
  localparam int BIT_PIN_FN   = 0;
  localparam int BIT_ST_EXT   = 0;
  localparam int BIT_ST_SWBSY = 1;
  localparam int BIT_ST_GUARD = 2;
  localparam int BIT_ST_WURUN = 3;
  localparam int EV_WU_DONE   = 0;
  localparam int EV_SW_DONE   = 1;
  localparam int EV_CLK_FAULT = 2;
  localparam int NUM_EV       = 3;
  // ==========================================================================
  // Reset values
  localparam logic       RST_SRC_SEL = 1'b0;
  localparam logic       RST_INT_EN  = 1'b1;
  localparam logic       RST_EXT_EN  = 1'b0;
  localparam logic       RST_SLOW    = 1'b0;
  localparam logic       RST_PIN_FN  = 1'b0;
  localparam logic [7:0] RST_WU_CMP  = 8'h66;
  // ==========================================================================
  // Timing
  localparam logic [1:0] MC_WAIT     = 2'h2;
  localparam int         WU_CNT_W    = 14;
  localparam int         WU_CMP_LSB  = 6;
  // ==========================================================================
  // Warm-up source
  typedef enum logic [0:0] {
    WU_SRC_INT = 1'b0,
    WU_SRC_EXT = 1'b1
  } hfcs_wu_src_t;
endpackage

//--- hw/hfcs_glitch_sw.sv
`timescale 1ns/100ps
`default_nettype none
module hfcs_glitch_sw
  import hfcs_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_int_clk,
  input  wire logic i_ext_clk,
  input  wire logic i_sel_ext,
  output logic      o_int_on,
  output logic      o_ext_on,
  output logic      o_hf_ref_clk
);
  logic int_d_ff;
  logic ext_d_ff;
  logic int_s1_ff;
  logic int_s2_ff;
  logic ext_s1_ff;
  logic ext_s2_ff;
  logic int_fall;
  logic ext_fall;
  logic hf_ff;

  // ==========================================================================
  // Edge detection
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_d_ff <= 1'b0;
      ext_d_ff <= 1'b0;
    end else begin
      int_d_ff <= i_int_clk;
      ext_d_ff <= i_ext_clk;
    end
  end

  assign int_fall = int_d_ff & ~i_int_clk;
  assign ext_fall = ext_d_ff & ~i_ext_clk;

  // ==========================================================================
  // Enable chains, each stepped on its own source's falling edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_s1_ff <= 1'b1;
      int_s2_ff <= 1'b1;
    end else if (int_fall) begin
      int_s1_ff <= ~i_sel_ext & ~ext_s2_ff; // see RL19
      int_s2_ff <= int_s1_ff;               // see RL5
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
    end else if (ext_fall) begin
      ext_s1_ff <= i_sel_ext & ~int_s2_ff;  // see RL19
      ext_s2_ff <= ext_s1_ff;               // see RL5
    end
  end

  // ==========================================================================
  // Gated output
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hf_ff <= 1'b0;
    end else begin
      hf_ff <= (i_int_clk & int_s2_ff) | (i_ext_clk & ext_s2_ff); // see RL1
    end
  end

  assign o_int_on     = int_s2_ff;
  assign o_ext_on     = ext_s2_ff;
  assign o_hf_ref_clk = hf_ff;

  a_new_after_old: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RL19
    $rose(ext_s2_ff) |-> $past(!i_ext_clk) && !int_s2_ff)
    else $error("External enable rose while clock high or internal still on");
endmodule // hfcs_glitch_sw
`default_nettype wire

//--- hw/hfcs_top.sv
// Function
// RL1: Select bit 1 drives the reference clock from external, 0 from internal.
// RL2: Reset clears the select bit, so internal oscillator drives the reference.
// RL3: Change to external ends within 2 internal plus 2.5 external periods.
// RL4: Change to internal ends within 2 external plus 2.5 internal periods.
// RL5: Oscillators are synchronised; reference stops at most 2.5 new periods.
// RL6: Clearing internal enable during change to external raises clock reset.
// RL7: Clearing external enable during change to internal raises clock reset.
// RL8: Stopping old oscillator within 2 machine cycles of select raises reset.
// RL9: Select bit writes ignored while slow select bit is 1.
// RL10: External enable set while pin function bit is 0 raises clock reset.
// RL11: Rewriting external enable while already 1 does not restart warm-up.
// RL12: Enabling an oscillator starts it and warm-up; done raises an interrupt.
// RL13: Pin function 0 gives ordinary ports, 1 gives oscillator pins.
// RL14: Software order to external: pins, enable, warm-up, select, wait, stop.
// RL15: Software order to internal: enable, warm-up, select, wait, stop.
// RL16: Software keeps both oscillators running while changing the source.
// RL17: No mode changes with both enabled; stop the unused one after switch.
// RL18: Selected oscillator disabled while reference is main clock raises reset.
// RL19: Glitch-free switch: old clock low first, then new synchronised enable.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module hfcs_top
  import hfcs_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_int_osc,
  input  wire logic        i_osc_in_pin_i,
  input  wire logic        i_osc_out_pin_i,
  input  wire logic [1:0]  i_port_o,
  input  wire logic [1:0]  i_port_oe,
  output logic      [1:0]  o_port_i,
  output logic             o_osc_in_pin_o,
  output logic             o_osc_in_pin_oe,
  output logic             o_osc_out_pin_o,
  output logic             o_osc_out_pin_oe,
  output logic             o_int_osc_en,
  output logic             o_ext_osc_en,
  output logic             o_hf_ref_clk,
  output logic             o_sys_clk_rst,
  output logic             o_irq
);
  logic              src_sel_ff;
  logic              int_en_ff;
  logic              ext_en_ff;
  logic              slow_ff;
  logic              pin_fn_ff;
  logic [7:0]        wu_cmp_ff;
  logic              wu_run_ff;
  hfcs_wu_src_t      wu_src_ff;
  logic [WU_CNT_W-1:0] wu_cnt_ff;
  logic              wu_src_d_ff;
  logic [1:0]        guard_ff;
  logic              hf_d_ff;
  logic              busy_d_ff;
  logic              rst_ff;
  logic [NUM_EV-1:0] irq_stat_ff;
  logic [NUM_EV-1:0] irq_mask_ff;
  logic              irq_ff;
  logic [31:0]       prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;
  logic [1:0]        port_i_ff;
  logic              in_o_ff;
  logic              in_oe_ff;
  logic              out_o_ff;
  logic              out_oe_ff;
  logic              setup;
  logic              wr;
  logic              wr_one;
  logic              wr_two;
  logic              int_clk;
  logic              ext_clk;
  logic              sw_int_on;
  logic              sw_ext_on;
  logic              sw_busy;
  logic              guard_busy;
  logic              chg_busy;
  logic              fault_c;
  logic              wu_src_lvl;
  logic              wu_edge;
  logic              ext_start;
  logic              int_start;
  logic [NUM_EV-1:0] ev;
  logic [31:0]       nxt_rdata;
  logic              nxt_err;

  // ==========================================================================
  // APB access
  assign setup  = i_psel & ~i_penable;
  assign wr     = i_psel & i_penable & i_pwrite & pready_ff;
  assign wr_one = wr & (i_paddr == OFS_CTRL_ONE);
  assign wr_two = wr & (i_paddr == OFS_CTRL_TWO);

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_err   = 1'b0;
    unique case (i_paddr)
      OFS_CTRL_ONE: nxt_rdata[BIT_SRC_SEL] = src_sel_ff;
      OFS_CTRL_TWO: begin
        nxt_rdata[BIT_INT_EN]   = int_en_ff;
        nxt_rdata[BIT_EXT_EN]   = ext_en_ff;
        nxt_rdata[BIT_SLOW_SEL] = slow_ff;
      end
      OFS_PORT_FN:  nxt_rdata[BIT_PIN_FN] = pin_fn_ff;
      OFS_WU_CMP:   nxt_rdata[7:0] = wu_cmp_ff;
      OFS_STATUS: begin
        nxt_rdata[BIT_ST_EXT]   = sw_ext_on;
        nxt_rdata[BIT_ST_SWBSY] = sw_busy;
        nxt_rdata[BIT_ST_GUARD] = guard_busy;
        nxt_rdata[BIT_ST_WURUN] = wu_run_ff;
      end
      OFS_IRQ_STAT: nxt_rdata[NUM_EV-1:0] = irq_stat_ff;
      OFS_IRQ_MASK: nxt_rdata[NUM_EV-1:0] = irq_mask_ff;
      default:      nxt_err = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & nxt_err;
      prdata_ff  <= (setup && !i_pwrite) ? nxt_rdata : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      src_sel_ff <= RST_SRC_SEL; // see RL2
    end else if (wr_one && !slow_ff) begin
      src_sel_ff <= i_pwdata[BIT_SRC_SEL]; // see RL9
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_en_ff <= RST_INT_EN;
      ext_en_ff <= RST_EXT_EN;
      slow_ff   <= RST_SLOW;
    end else if (wr_two) begin
      int_en_ff <= i_pwdata[BIT_INT_EN];
      ext_en_ff <= i_pwdata[BIT_EXT_EN];
      slow_ff   <= i_pwdata[BIT_SLOW_SEL];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_fn_ff <= RST_PIN_FN;
      wu_cmp_ff <= RST_WU_CMP;
    end else begin
      if (wr && i_paddr == OFS_PORT_FN) begin
        pin_fn_ff <= i_pwdata[BIT_PIN_FN];
      end
      if (wr && i_paddr == OFS_WU_CMP) begin
        wu_cmp_ff <= i_pwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Oscillator gating and shared pins
  assign int_clk = i_int_osc & int_en_ff;
  assign ext_clk = i_osc_in_pin_i & pin_fn_ff & ext_en_ff; // see RL13

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      port_i_ff <= 2'h0;
      in_o_ff   <= 1'b0;
      in_oe_ff  <= 1'b0;
      out_o_ff  <= 1'b0;
      out_oe_ff <= 1'b0;
    end else if (pin_fn_ff) begin
      port_i_ff <= 2'h0; // see RL13
      in_o_ff   <= 1'b0;
      in_oe_ff  <= 1'b0;
      out_o_ff  <= ~i_osc_in_pin_i;
      out_oe_ff <= ext_en_ff;
    end else begin
      port_i_ff <= {i_osc_out_pin_i, i_osc_in_pin_i}; // see RL13
      in_o_ff   <= i_port_o[0];
      in_oe_ff  <= i_port_oe[0];
      out_o_ff  <= i_port_o[1];
      out_oe_ff <= i_port_oe[1];
    end
  end

  // ==========================================================================
  // Reference clock switch
  hfcs_glitch_sw u_sw (
    .i_clk        (i_clk),
    .i_rst_b      (i_rst_b),
    .i_int_clk    (int_clk),
    .i_ext_clk    (ext_clk),
    .i_sel_ext    (src_sel_ff),
    .o_int_on     (sw_int_on),
    .o_ext_on     (sw_ext_on),
    .o_hf_ref_clk (o_hf_ref_clk)
  );

  // Busy until the new source alone is enabled
  assign sw_busy = src_sel_ff ? (~sw_ext_on | sw_int_on) : (~sw_int_on | sw_ext_on); // see RL3 see RL4

  // Two machine cycles counted on reference clock rising edges
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      guard_ff <= 2'h0;
      hf_d_ff  <= 1'b0;
    end else begin
      hf_d_ff <= o_hf_ref_clk;
      if (wr_one && !slow_ff && (i_pwdata[BIT_SRC_SEL] != src_sel_ff)) begin
        guard_ff <= MC_WAIT; // see RL8
      end else if (!sw_busy && guard_ff != 2'h0 && o_hf_ref_clk && !hf_d_ff) begin
        guard_ff <= guard_ff - 2'h1;
      end
    end
  end

  assign guard_busy = (guard_ff != 2'h0);
  assign chg_busy   = sw_busy | guard_busy;

  // ==========================================================================
  // System clock reset
  always_comb begin
    fault_c = 1'b0;
    if (!int_en_ff && (chg_busy || (!slow_ff && !src_sel_ff))) begin
      fault_c = 1'b1; // see RL6 see RL8 see RL18
    end
    if (!ext_en_ff && (chg_busy || (!slow_ff && src_sel_ff))) begin
      fault_c = 1'b1; // see RL7 see RL8 see RL18
    end
    if (ext_en_ff && !pin_fn_ff) begin
      fault_c = 1'b1; // see RL10
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_ff <= 1'b0;
    end else begin
      rst_ff <= fault_c;
    end
  end

  // ==========================================================================
  // Warm-up counter
  assign ext_start  = wr_two & i_pwdata[BIT_EXT_EN] & ~ext_en_ff; // see RL11
  assign int_start  = wr_two & i_pwdata[BIT_INT_EN] & ~int_en_ff;
  assign wu_src_lvl = (wu_src_ff == WU_SRC_EXT) ? ext_clk : int_clk;
  assign wu_edge    = wu_src_lvl & ~wu_src_d_ff;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wu_run_ff   <= 1'b0;
      wu_src_ff   <= WU_SRC_INT;
      wu_cnt_ff   <= '0;
      wu_src_d_ff <= 1'b0;
    end else begin
      wu_src_d_ff <= wu_src_lvl;
      if (ext_start || int_start) begin
        wu_run_ff <= 1'b1; // see RL12
        wu_src_ff <= ext_start ? WU_SRC_EXT : WU_SRC_INT;
        wu_cnt_ff <= '0;
      end else if (wu_run_ff && wu_cnt_ff[WU_CNT_W-1:WU_CMP_LSB] == wu_cmp_ff) begin
        wu_run_ff <= 1'b0;
      end else if (wu_run_ff && wu_edge) begin
        wu_cnt_ff <= wu_cnt_ff + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Interrupts
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_d_ff <= 1'b0;
    end else begin
      busy_d_ff <= sw_busy;
    end
  end

  assign ev[EV_WU_DONE]   = wu_run_ff & (wu_cnt_ff[WU_CNT_W-1:WU_CMP_LSB] == wu_cmp_ff)
                            & ~ext_start & ~int_start; // see RL12
  assign ev[EV_SW_DONE]   = busy_d_ff & ~sw_busy;
  assign ev[EV_CLK_FAULT] = fault_c & ~rst_ff;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff      <= 1'b0;
    end else begin
      if (wr && i_paddr == OFS_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~i_pwdata[NUM_EV-1:0]) | ev;
      end else begin
        irq_stat_ff <= irq_stat_ff | ev;
      end
      if (wr && i_paddr == OFS_IRQ_MASK) begin
        irq_mask_ff <= i_pwdata[NUM_EV-1:0];
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ==========================================================================
  // Outputs
  assign o_prdata         = prdata_ff;
  assign o_pready         = pready_ff;
  assign o_pslverr        = pslverr_ff;
  assign o_port_i         = port_i_ff;
  assign o_osc_in_pin_o   = in_o_ff;
  assign o_osc_in_pin_oe  = in_oe_ff;
  assign o_osc_out_pin_o  = out_o_ff;
  assign o_osc_out_pin_oe = out_oe_ff;
  assign o_int_osc_en     = int_en_ff;
  assign o_ext_osc_en     = ext_en_ff;
  assign o_sys_clk_rst    = rst_ff;
  assign o_irq            = irq_ff;

  // ==========================================================================
  // Assertions
  a_select_write_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RL9
    $changed(src_sel_ff) |-> $past(wr_one) && !$past(slow_ff))
    else $error("Select bit changed without a write in normal mode");

  a_ref_follows_src: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RL1
    !sw_busy |=> o_hf_ref_clk == $past(src_sel_ff ? ext_clk : int_clk))
    else $error("Reference clock not following the selected source");

  a_int_stop_reset: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RL6
    (!int_en_ff && src_sel_ff && chg_busy) |=> o_sys_clk_rst)
    else $error("No clock reset on internal stop during change");

  a_ext_stop_reset: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RL7
    (!ext_en_ff && !src_sel_ff && chg_busy) |=> o_sys_clk_rst)
    else $error("No clock reset on external stop during change");

  a_pin_fn_reset: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RL10
    (ext_en_ff && !pin_fn_ff) |=> o_sys_clk_rst)
    else $error("No clock reset with external enabled on plain ports");

  a_main_dead_reset: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RL18
    (!slow_ff && !src_sel_ff && !int_en_ff) |=> o_sys_clk_rst)
    else $error("No clock reset with selected source stopped");

  a_wu_no_restart: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RL11
    (wr_two && i_pwdata[BIT_EXT_EN] && ext_en_ff && !int_start && wu_cnt_ff != '0)
    |=> wu_cnt_ff != '0)
    else $error("Warm-up restarted by a repeated enable write");

  a_wu_start: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RL12
    $rose(ext_en_ff) |-> wu_run_ff && wu_cnt_ff == '0 && wu_src_ff == WU_SRC_EXT)
    else $error("Warm-up not started with external oscillator");

  a_pin_release: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RL13
    pin_fn_ff |=> !o_osc_in_pin_oe)
    else $error("Input pin driven while used as oscillator pin");
endmodule // hfcs_top
`default_nettype wire

//--- verification/hfcs_xtal_model.sv
`timescale 1ns/100ps
`default_nettype none
module hfcs_xtal_model #(
  parameter int HALF_NS = 120
) (
  input  wire logic i_run,
  output logic      o_clk
);
  // ==========================================================================
  // Oscillation, stops at its last level when disabled
  initial begin
    o_clk = 1'b0;
    forever begin
      #(HALF_NS);
      o_clk = i_run ? ~o_clk : o_clk;
    end
  end
endmodule // hfcs_xtal_model
`default_nettype wire

//--- verification/hfcs_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module hfcs_top_test
  import hfcs_pkg::*;
;
  localparam int TI      = 8;
  localparam int TE      = 6;
  localparam int LIM_EXT = 2 * TI + (5 * TE) / 2 + 8;
  localparam int LIM_INT = 2 * TE + (5 * TI) / 2 + 8;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        int_osc;
  logic        xtal;
  logic        in_pin;
  logic        out_pin;
  logic        out_last = 1'b0;
  logic [1:0]  port_o;
  logic [1:0]  port_oe;
  logic [1:0]  port_i;
  logic        in_o;
  logic        in_oe;
  logic        out_o;
  logic        out_oe;
  logic        int_en;
  logic        ext_en;
  logic        hf_ref;
  logic        sys_rst;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          n_fail;
  int          check_count;
  int          cyc = 0;
  int          t0;
  int          t_sw;
  // ==========================================================================
  // Clock, oscillators and pins
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    int_osc = 1'b0;
    forever begin
      #(TI * 20);
      int_osc = int_en ? ~int_osc : int_osc;
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    out_last <= out_pin;
  end
  assign in_pin  = in_oe ? in_o : xtal;
  assign out_pin = out_oe ? out_o : ~out_last;
  hfcs_xtal_model #(.HALF_NS(TE * 20)) i_hfcs_xtal_model (.i_run(ext_en), .o_clk(xtal));
  hfcs_top i_hfcs_top (
    .i_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_int_osc(int_osc), .i_osc_in_pin_i(in_pin), .i_osc_out_pin_i(out_pin), .i_port_o(port_o),
    .i_port_oe(port_oe), .o_port_i(port_i), .o_osc_in_pin_o(in_o), .o_osc_in_pin_oe(in_oe),
    .o_osc_out_pin_o(out_o), .o_osc_out_pin_oe(out_oe), .o_int_osc_en(int_en),
    .o_ext_osc_en(ext_en), .o_hf_ref_clk(hf_ref), .o_sys_clk_rst(sys_rst), .o_irq(irq));
  // ==========================================================================
  // Tasks
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(name, rd & mask, exp);
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic wait_switch();
    t0 = cyc;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
    end while (rd[BIT_ST_SWBSY] !== 1'b0);
    t_sw = cyc - t0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
    end while (rd[BIT_ST_GUARD] !== 1'b0);
  endtask
  // ==========================================================================
  // Tests
  initial begin
    #(40 * 40000);
    n_fail++;
    end_of_test();
  end
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, port_o, port_oe} = '0;
    {n_fail, check_count} = '0;
    do_reset();
    rdc("sel", OFS_CTRL_ONE, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc("ctl2", OFS_CTRL_TWO, 32'hFFFF_FFFF, 32'h0000_0001);
    rdc("cmp", OFS_WU_CMP, 32'hFFFF_FFFF, 32'h0000_0066);
    rdc("stat", OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc("unmap", 8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
    check("slverr", err, 1);
    check("int_en", int_en, 1);
    port_oe <= 2'b11;
    port_o  <= 2'b11;
    repeat (4) @(posedge clk);
    check("gpio_oe", in_oe, 1);
    check("gpio_oe1", out_oe, 1);
    check("gpio_o", {out_o, in_o}, 2'b11);
    check("gpio1", port_i, 2'b11);
    port_o  <= 2'b00;
    repeat (4) @(posedge clk);
    check("gpio0", port_i, 2'b00);
    port_oe <= 2'b00;
    wr(OFS_CTRL_TWO, 32'h0000_0003);
    repeat (2) @(posedge clk);
    check("pin_flt", sys_rst, 1);
    check("irq_msk", irq, 0);
    rdc("flt_st", OFS_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
    wr(OFS_IRQ_MASK, 32'h0000_0004);
    repeat (2) @(posedge clk);
    check("irq_on", irq, 1);
    wr(OFS_CTRL_TWO, 32'h0000_0001);
    wr(OFS_IRQ_STAT, 32'h0000_0004);
    repeat (2) @(posedge clk);
    check("flt_off", sys_rst, 0);
    check("irq_clr", irq, 0);
    do_reset();
    wr(OFS_WU_CMP, 32'h0000_0001);
    wr(OFS_PORT_FN, 32'h0000_0001);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    wr(OFS_CTRL_TWO, 32'h0000_0003);
    repeat (2) @(posedge clk);
    check("osc_oe", out_oe, 1);
    check("ext_en", ext_en, 1);
    check("no_flt", sys_rst, 0);
    wait_irq();
    check("wu_irq", irq, 1);
    wr(OFS_IRQ_STAT, 32'h0000_0001);
    wr(OFS_CTRL_TWO, 32'h0000_0003);
    rdc("wu_idle", OFS_STATUS, 32'h0000_0008, 32'h0000_0000);
    check("irq_rep", irq, 0);
    wr(OFS_CTRL_ONE, 32'h0000_0001);
    wait_switch();
    check("lat_ext", t_sw <= LIM_EXT, 1);
    check("on_ext", rd[0], 1);
    @(posedge hf_ref);
    check("ref_ext", xtal, 1);
    rdc("sw_done", OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
    wr(OFS_CTRL_TWO, 32'h0000_0002);
    repeat (2) @(posedge clk);
    check("int_off", sys_rst, 0);
    wr(OFS_CTRL_TWO, 32'h0000_0006);
    wr(OFS_CTRL_ONE, 32'h0000_0000);
    rdc("slow_sel", OFS_CTRL_ONE, 32'h0000_0001, 32'h0000_0001);
    wr(OFS_CTRL_TWO, 32'h0000_0002);
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    wr(OFS_CTRL_TWO, 32'h0000_0003);
    wait_irq();
    check("wu_int", irq, 1);
    wr(OFS_IRQ_STAT, 32'h0000_0001);
    wr(OFS_CTRL_ONE, 32'h0000_0000);
    wr(OFS_CTRL_TWO, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check("early", sys_rst, 1);
    wr(OFS_CTRL_TWO, 32'h0000_0003);
    wait_switch();
    check("lat_int", t_sw <= LIM_INT + 12, 1);
    check("on_int", rd[0], 0);
    @(posedge hf_ref);
    check("ref_int", int_osc, 1);
    wr(OFS_CTRL_TWO, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check("ext_off", sys_rst, 0);
    wr(OFS_CTRL_TWO, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check("sel_off", sys_rst, 1);
    wr(OFS_CTRL_TWO, 32'h0000_0003);
    wr(OFS_CTRL_ONE, 32'h0000_0001);
    wr(OFS_CTRL_TWO, 32'h0000_0002);
    repeat (2) @(posedge clk);
    check("early_ext", sys_rst, 1);
    end_of_test();
  end
endmodule // hfcs_top_test
`default_nettype wire
